// >>> rtl/mmrb_defines.svh
// register offsets, field positions, reset values and timing counts of the meter macro register bank
`ifndef MMRB_DEFINES_SVH
`define MMRB_DEFINES_SVH

// register indices as printed; byte address is four times the index
`define MMRB_IDX_TOT2_CFG 12'h324
`define MMRB_IDX_VAR_FLOAT 12'h325
`define MMRB_IDX_VAR_FIXED 12'h326
`define MMRB_IDX_RX_FLAGS 12'h327
`define MMRB_IDX_EXP_OUT 12'h328
`define MMRB_IDX_IRQ_STATUS 12'h329
`define MMRB_IDX_IRQ_MASK 12'h32a
`define MMRB_IDX_STR_CHAR 12'h32b
`define MMRB_IDX_STR_LEN 12'h32c
`define MMRB_IDX_TOT2_STATUS 12'h32d

// totaliser configuration fields
`define MMRB_TOT_PERIOD_LSB 0
`define MMRB_TOT_PERIOD_W 4
`define MMRB_TOT_ROLL_BIT 4
`define MMRB_TOT_PERIOD_MAX 4'h7

// interrupt status bits
`define MMRB_IRQ_RX_BIT 0
`define MMRB_IRQ_PERIOD_BIT 1
`define MMRB_IRQ_W 2

// reset values
`define MMRB_RST_TOT2_CFG 8'h00
`define MMRB_RST_VAR 32'h00000000
`define MMRB_RST_EXP_OUT 32'h00000000
`define MMRB_RST_STR_CHAR 8'h0d
`define MMRB_RST_STR_LEN 8'h00

// time base: 20 MHz clock, one second tick
`define MMRB_CLK_HZ 20000000
`define MMRB_SECOND_S 1
`define MMRB_SECOND_CYCLES (`MMRB_CLK_HZ * `MMRB_SECOND_S)

`endif

// >>> rtl/mmrb_pkg.sv
// types shared by the meter macro register bank
package mmrb_pkg;

    typedef enum logic [3:0] {
        MMRB_P_1S,
        MMRB_P_10S,
        MMRB_P_1MIN,
        MMRB_P_10MIN,
        MMRB_P_1H,
        MMRB_P_10H,
        MMRB_P_1DAY,
        MMRB_P_1WEEK
    } mmrb_period_t;

    typedef struct packed {
        logic [2:0] unused;
        logic roll_en;
        logic [3:0] period;
    } mmrb_tot_cfg_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } mmrb_rx_byte_t;

    typedef enum logic [1:0] {
        MMRB_RX_HUNT,
        MMRB_RX_COUNT
    } mmrb_rx_state_t;

endpackage : mmrb_pkg

// >>> rtl/mmrb_period_timer.sv
// k-factor period timer for the second totaliser
`timescale 1ns/10ps
`include "mmrb_defines.svh"
module mmrb_period_timer
    import mmrb_pkg::*;
#(
    parameter int SECOND_CYCLES = `MMRB_SECOND_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // configuration
    input wire logic [3:0] period_code,
    // period end pulse
    output logic period_tick
);

    logic [24:0] sec_reg;
    logic [24:0] sec_next;
    logic [19:0] secs_reg;
    logic [19:0] secs_next;
    logic tick_reg;
    logic tick_next;

    // seconds per selected period; codes above seven fall back to one second
    function automatic logic [19:0] period_secs(input logic [3:0] code);
        unique case (code)
            4'h0: period_secs = 20'd1;
            4'h1: period_secs = 20'd10;
            4'h2: period_secs = 20'd60;
            4'h3: period_secs = 20'd600;
            4'h4: period_secs = 20'd3600;
            4'h5: period_secs = 20'd36000;
            4'h6: period_secs = 20'd86400;
            4'h7: period_secs = 20'd604800;
            default: period_secs = 20'd1;
        endcase
    endfunction : period_secs

    always_comb
    begin
        sec_next = sec_reg + 25'h1;
        secs_next = secs_reg;
        tick_next = 1'b0;
        if (sec_reg >= 25'(SECOND_CYCLES - 1))
        begin
            sec_next = 25'h0;
            secs_next = secs_reg + 20'h1;
            if (secs_reg + 20'h1 >= period_secs(period_code))
            begin
                secs_next = 20'h0;
                tick_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sec_reg <= 25'h0;
            secs_reg <= 20'h0;
            tick_reg <= 1'b0;
        end
        else
        begin
            sec_reg <= sec_next;
            secs_reg <= secs_next;
            tick_reg <= tick_next;
        end
    end

    assign period_tick = tick_reg;

endmodule : mmrb_period_timer

// >>> rtl/mmrb_rx_framer.sv
// master-mode message framer: terminator or start plus byte count
`timescale 1ns/10ps
`include "mmrb_defines.svh"
module mmrb_rx_framer
    import mmrb_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // received bytes
    input wire mmrb_rx_byte_t rx_in,
    // framing configuration
    input wire logic [7:0] str_char,
    input wire logic [7:0] str_len,
    // completion pulse
    output logic msg_done
);

    mmrb_rx_state_t state_reg;
    mmrb_rx_state_t state_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic done_reg;
    logic done_next;

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        done_next = 1'b0;
        if (rx_in.valid)
        begin
            unique case (state_reg)
                MMRB_RX_HUNT:
                begin
                    if (str_len == 8'h00)
                        done_next = (rx_in.data == str_char);
                    else if (rx_in.data == str_char)
                    begin
                        state_next = MMRB_RX_COUNT;
                        cnt_next = 8'h00;
                    end
                end
                MMRB_RX_COUNT:
                begin
                    cnt_next = cnt_reg + 8'h01;
                    if (cnt_reg + 8'h01 >= str_len)
                    begin
                        done_next = 1'b1;
                        state_next = MMRB_RX_HUNT;
                    end
                end
                default:
                    state_next = MMRB_RX_HUNT;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= MMRB_RX_HUNT;
            cnt_reg <= 8'h00;
            done_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign msg_done = done_reg;

    // back-to-back terminators may complete in consecutive cycles, so only the cause is checked
    done_after_byte_a: assert property (@(posedge clk) disable iff (!rstn)
        msg_done |-> $past(rx_in.valid))
        else $error("completion without a received byte");

endmodule : mmrb_rx_framer

// >>> rtl/mmrb_top.sv
// meter macro register bank: apb slave, totaliser config, shared variable, rx flag, expansion outputs
//
// Functional notes
// - second totaliser config sets period and roll-over
// - low nibble codes 0-7 pick k-factor period
// - bit 4 enables totaliser roll-over
// - bits 5-7 have no effect
// - two indices share one 32-bit word
// - float view returns raw stored bits
// - fixed view returns same bits, signed
// - bit 0 flags completed master-mode message
// - frame by terminator or start plus count
// - output bit n drives expansion output n+1
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`include "mmrb_defines.svh"
module mmrb_top
    import mmrb_pkg::*;
#(
    parameter int SECOND_CYCLES = `MMRB_SECOND_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial receive bytes, same clock
    input wire mmrb_rx_byte_t rx_in,
    // totaliser two control
    output logic tot2_roll_en,
    output logic [3:0] tot2_period,
    output logic tot2_period_tick,
    // expansion outputs
    output logic [31:0] exp_out,
    // interrupt
    output logic irq
);

    mmrb_tot_cfg_t tot_reg;
    mmrb_tot_cfg_t tot_next;
    logic [31:0] var_reg;
    logic [31:0] var_next;
    logic rx_ready_reg;
    logic rx_ready_next;
    logic [31:0] exp_reg;
    logic [31:0] exp_next;
    logic [7:0] str_char_reg;
    logic [7:0] str_char_next;
    logic [7:0] str_len_reg;
    logic [7:0] str_len_next;
    logic [`MMRB_IRQ_W-1:0] ists_reg;
    logic [`MMRB_IRQ_W-1:0] ists_next;
    logic [`MMRB_IRQ_W-1:0] imask_reg;
    logic [`MMRB_IRQ_W-1:0] imask_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic irq_reg;
    logic irq_next;
    logic tick_out_reg;
    logic msg_done;
    logic period_tick;
    logic [11:0] idx;
    logic acc;
    logic wr;
    logic mapped;
    logic [31:0] rd_word;

    // byte-lane merge, used for the totaliser config, shared variable and expansion output registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[i*8 +: 8] = wd[i*8 +: 8];
        return r;
    endfunction : lane_merge

    mmrb_period_timer #(
        .SECOND_CYCLES(SECOND_CYCLES)
    ) u_timer (
        .clk(clk),
        .rstn(rstn),
        .period_code(tot_reg.period),
        .period_tick(period_tick)
    );

    mmrb_rx_framer u_framer (
        .clk(clk),
        .rstn(rstn),
        .rx_in(rx_in),
        .str_char(str_char_reg),
        .str_len(str_len_reg),
        .msg_done(msg_done)
    );

    assign idx = paddr[13:2];
    // access phase, answered in the second cycle with pready one cycle later
    assign acc = psel && penable && !pready_reg;
    assign wr = acc && pwrite;

    always_comb
    begin
        mapped = 1'b1;
        rd_word = 32'h0;
        unique case (idx)
            `MMRB_IDX_TOT2_CFG: rd_word = {24'h0, tot_reg};
            `MMRB_IDX_VAR_FLOAT: rd_word = var_reg;
            `MMRB_IDX_VAR_FIXED: rd_word = var_reg;
            `MMRB_IDX_RX_FLAGS: rd_word = {31'h0, rx_ready_reg};
            `MMRB_IDX_EXP_OUT: rd_word = exp_reg;
            `MMRB_IDX_IRQ_STATUS: rd_word = {30'h0, ists_reg};
            `MMRB_IDX_IRQ_MASK: rd_word = {30'h0, imask_reg};
            `MMRB_IDX_STR_CHAR: rd_word = {24'h0, str_char_reg};
            `MMRB_IDX_STR_LEN: rd_word = {24'h0, str_len_reg};
            `MMRB_IDX_TOT2_STATUS: rd_word = {31'h0, tick_out_reg};
            default: mapped = 1'b0;
        endcase
        if (paddr[1:0] != 2'b00)
            mapped = 1'b0;
    end

    always_comb
    begin
        logic [31:0] m;
        m = 32'h0;
        tot_next = tot_reg;
        var_next = var_reg;
        rx_ready_next = rx_ready_reg;
        exp_next = exp_reg;
        str_char_next = str_char_reg;
        str_len_next = str_len_reg;
        ists_next = ists_reg;
        imask_next = imask_reg;
        prdata_next = prdata_reg;
        pready_next = acc;
        pslverr_next = acc && !mapped;
        if (acc && !pwrite)
            prdata_next = mapped ? rd_word : 32'h0;
        if (wr && mapped)
        begin
            unique case (idx)
                `MMRB_IDX_TOT2_CFG:
                begin
                    m = lane_merge({24'h0, tot_reg}, pwdata, pstrb);
                    tot_next = mmrb_tot_cfg_t'(m[7:0]);
                end
                `MMRB_IDX_VAR_FLOAT, `MMRB_IDX_VAR_FIXED: var_next = lane_merge(var_reg, pwdata, pstrb);
                `MMRB_IDX_RX_FLAGS:
                begin
                    if (pstrb[0] && !pwdata[0])
                        rx_ready_next = 1'b0;
                end
                `MMRB_IDX_EXP_OUT: exp_next = lane_merge(exp_reg, pwdata, pstrb);
                `MMRB_IDX_IRQ_STATUS:
                begin
                    if (pstrb[0])
                        ists_next = ists_reg & ~pwdata[`MMRB_IRQ_W-1:0];
                end
                `MMRB_IDX_IRQ_MASK:
                begin
                    if (pstrb[0])
                        imask_next = pwdata[`MMRB_IRQ_W-1:0];
                end
                `MMRB_IDX_STR_CHAR:
                begin
                    if (pstrb[0])
                        str_char_next = pwdata[7:0];
                end
                `MMRB_IDX_STR_LEN:
                begin
                    if (pstrb[0])
                        str_len_next = pwdata[7:0];
                end
                default:
                    m = 32'h0;
            endcase
        end
        // set wins over a clear in the same cycle
        if (msg_done)
        begin
            rx_ready_next = 1'b1;
            ists_next[`MMRB_IRQ_RX_BIT] = 1'b1;
        end
        if (period_tick)
            ists_next[`MMRB_IRQ_PERIOD_BIT] = 1'b1;
        irq_next = |(ists_next & imask_next);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tot_reg <= mmrb_tot_cfg_t'(`MMRB_RST_TOT2_CFG);
            var_reg <= `MMRB_RST_VAR;
            rx_ready_reg <= 1'b0;
            exp_reg <= `MMRB_RST_EXP_OUT;
            str_char_reg <= `MMRB_RST_STR_CHAR;
            str_len_reg <= `MMRB_RST_STR_LEN;
            ists_reg <= '0;
            imask_reg <= '0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
            tick_out_reg <= 1'b0;
        end
        else
        begin
            tot_reg <= tot_next;
            var_reg <= var_next;
            rx_ready_reg <= rx_ready_next;
            exp_reg <= exp_next;
            str_char_reg <= str_char_next;
            str_len_reg <= str_len_next;
            ists_reg <= ists_next;
            imask_reg <= imask_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
            tick_out_reg <= period_tick;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    // bits 5-7 never reach the totaliser outputs; they only read back on prdata
    assign tot2_roll_en = tot_reg.roll_en;
    assign tot2_period = tot_reg.period;
    assign tot2_period_tick = tick_out_reg;
    // expansion fitting is the far side's concern; the word is driven regardless
    assign exp_out = exp_reg;
    assign irq = irq_reg;

    shared_word_a: assert property (@(posedge clk) disable iff (!rstn)
        (wr && mapped && idx == `MMRB_IDX_VAR_FLOAT && pstrb == 4'hf)
        |=> var_reg == $past(pwdata))
        else $error("shared variable not updated by float view write");

    fixed_view_a: assert property (@(posedge clk) disable iff (!rstn)
        (acc && !pwrite && mapped && idx == `MMRB_IDX_VAR_FIXED) |=> prdata == $past(var_reg))
        else $error("fixed view read differs from stored word");

    float_view_a: assert property (@(posedge clk) disable iff (!rstn)
        (acc && !pwrite && mapped && idx == `MMRB_IDX_VAR_FLOAT) |=> prdata == $past(var_reg))
        else $error("float view read differs from stored word");

    rx_set_a: assert property (@(posedge clk) disable iff (!rstn)
        msg_done |=> rx_ready_reg)
        else $error("ready flag not set after message");

    rx_sticky_a: assert property (@(posedge clk) disable iff (!rstn)
        (rx_ready_reg && !(wr && idx == `MMRB_IDX_RX_FLAGS)) |=> rx_ready_reg)
        else $error("ready flag dropped without clear");

    exp_follow_a: assert property (@(posedge clk) disable iff (!rstn)
        (wr && mapped && idx == `MMRB_IDX_EXP_OUT && pstrb == 4'hf) |=> exp_out == $past(pwdata))
        else $error("expansion outputs not following write");

    upper_bits_a: assert property (@(posedge clk) disable iff (!rstn)
        $changed(tot_reg.unused) && $stable(tot_reg.period) |-> $stable(tot2_period))
        else $error("unused config bits affected period");

    roll_cfg_a: assert property (@(posedge clk) disable iff (!rstn)
        (wr && mapped && idx == `MMRB_IDX_TOT2_CFG && pstrb[0])
        |=> tot2_roll_en == $past(pwdata[`MMRB_TOT_ROLL_BIT]) && tot2_period == $past(pwdata[3:0]))
        else $error("totaliser config not applied");

    apb_answer_a: assert property (@(posedge clk) disable iff (!rstn)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer not one cycle after access");

endmodule : mmrb_top

// >>> verif/mmrb_exp_model.sv
// behavioural model of the i/o expansion modules fed by the output word
`timescale 1ns/10ps
module mmrb_exp_model
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // output word from the register bank
    input wire logic [31:0] exp_out,
    // level at each expansion output, numbered from one
    output logic [32:1] do_active
);
    // modules refresh once a clock; a real module may lag further, so the bench waits
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            do_active <= '0;
        else
            do_active <= exp_out;
    end
endmodule : mmrb_exp_model

// >>> verif/tb.sv
// self-checking bench for the meter macro register bank
`timescale 1ns/10ps
module tb;
    import mmrb_pkg::*;
    localparam int SEC = 4;
    localparam logic [13:0] A_CFG = 14'hc90, A_FLT = 14'hc94, A_FIX = 14'hc98, A_RXF = 14'hc9c;
    localparam logic [13:0] A_OUT = 14'hca0, A_IST = 14'hca4, A_IMK = 14'hca8, A_CHR = 14'hcac;
    localparam logic [13:0] A_LEN = 14'hcb0;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [13:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    mmrb_rx_byte_t rx_in = '0;
    logic tot2_roll_en;
    logic [3:0] tot2_period;
    logic tot2_period_tick;
    logic [31:0] exp_out;
    logic irq;
    logic [32:1] do_active;
    logic [64:0] exq [$];
    logic [64:0] e;
    logic [31:0] v;
    logic [31:0] w;
    logic [7:0] cfg;
    int miscompares = 0;
    int n_tests = 0;
    int n;
    int per [4] = '{1, 10, 60, 600};
    logic [13:0] ra [8] = '{A_CFG, A_FLT, A_FIX, A_RXF, A_OUT, A_IMK, A_CHR, A_LEN};
    logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0d, 32'h0};
    logic [31:0] rm [8] = '{32'hff, 32'hffffffff, 32'hffffffff, 32'h1, 32'hffffffff, 32'h3, 32'hff, 32'hff};

    mmrb_top #(.SECOND_CYCLES(SEC)) u_mmrb_top (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_in(rx_in), .tot2_roll_en(tot2_roll_en), .tot2_period(tot2_period),
        .tot2_period_tick(tot2_period_tick), .exp_out(exp_out), .irq(irq));
    mmrb_exp_model u_mmrb_exp_model (.clk(clk), .rstn(rstn), .exp_out(exp_out), .do_active(do_active));

    always #25 clk = ~clk;

    task automatic report_and_stop;
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [32:0] got, input logic [32:0] want);
        n_tests++;
        if (got !== want)
        begin
            miscompares++;
            $display("MISMATCH %0t got %h want %h", $time, got, want);
        end
    endtask : chk

    task automatic hang;
        miscompares++;
        $display("MISMATCH %0t wait limit used up", $time);
        report_and_stop();
    endtask : hang

    // note the expected answer first; the monitor below compares it
    task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [31:0] m, input logic err);
        int i;
        exq.push_back({err, d, m});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 16 && pready !== 1'b1; i++)
            @(posedge clk);
        if (pready !== 1'b1)
            hang();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [13:0] a, input logic [31:0] d, input logic [31:0] m);
        apb(1'b0, a, d, 4'h0, m, 1'b0);
    endtask : rd

    task automatic send(input logic [7:0] b);
        rx_in <= '{valid: 1'b1, data: b};
        @(posedge clk);
        rx_in <= '{valid: 1'b0, data: ~b};
        @(posedge clk);
    endtask : send

    task automatic tick_wait(output int k);
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (tot2_period_tick !== 1'b1 && k < 3000);
        if (k >= 3000)
            hang();
    endtask : tick_wait

    // read data only counts under the mask; writes only check the error flag
    always @(posedge clk)
    begin
        if (rstn && psel && penable && pready === 1'b1)
        begin
            if (exq.size() == 0)
                chk(33'h1, 33'h0);
            else
            begin
                e = exq.pop_front();
                chk({pslverr, prdata & e[31:0]}, {e[64], e[63:32] & e[31:0]});
            end
        end
    end

    initial
    begin
        void'($urandom(63938));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++)
            rd(ra[i], rv[i], rm[i]);
        for (int c = 0; c < 4; c++)
        begin
            cfg = {3'($urandom()), 1'($urandom()), 4'(c)};
            wr(A_CFG, {24'h0, cfg}, 4'hf);
            repeat (2) @(posedge clk);
            chk({29'h0, tot2_period}, 33'(c));
            chk({32'h0, tot2_roll_en}, {32'h0, cfg[4]});
            rd(A_CFG, {24'h0, cfg}, 32'h1f);
            tick_wait(n);
            tick_wait(n);
            chk(33'(n), 33'(per[c] * SEC));
        end
        rd(A_IST, 32'h2, 32'h2);
        wr(A_IST, 32'h2, 4'hf);
        rd(A_IST, 32'h0, 32'h2);
        v = $urandom();
        w = $urandom();
        wr(A_FLT, v, 4'hf);
        rd(A_FIX, v, 32'hffffffff);
        wr(A_FIX, w, 4'h5);
        rd(A_FLT, {v[31:24], w[23:16], v[15:8], w[7:0]}, 32'hffffffff);
        wr(A_OUT, w, 4'hf);
        repeat (3) @(posedge clk);
        chk({1'b0, exp_out}, {1'b0, w});
        for (int i = 0; i < 32; i++)
            chk({32'h0, do_active[i + 1]}, {32'h0, w[i]});
        // terminator mode with a non-default character
        wr(A_IMK, 32'h1, 4'hf);
        wr(A_CHR, 32'h3a, 4'hf);
        send(8'h41);
        send(8'h3a);
        repeat (3) @(posedge clk);
        rd(A_RXF, 32'h1, 32'h1);
        chk({32'h0, irq}, 33'h1);
        wr(A_RXF, 32'h1, 4'h1);
        rd(A_RXF, 32'h1, 32'h1);
        wr(A_RXF, 32'h0, 4'h1);
        rd(A_RXF, 32'h0, 32'h1);
        wr(A_IST, 32'h1, 4'hf);
        repeat (2) @(posedge clk);
        chk({32'h0, irq}, 33'h0);
        wr(A_IMK, 32'h0, 4'hf);
        send(8'h3a);
        repeat (3) @(posedge clk);
        chk({32'h0, irq}, 33'h0);
        rd(A_IST, 32'h1, 32'h1);
        wr(A_IMK, 32'h1, 4'hf);
        repeat (2) @(posedge clk);
        chk({32'h0, irq}, 33'h1);
        wr(A_IST, 32'h1, 4'hf);
        wr(A_RXF, 32'h0, 4'h1);
        // start character then a byte count; the start byte itself is not counted
        wr(A_LEN, 32'h3, 4'hf);
        send(8'h55);
        send(8'h3a);
        send(8'($urandom()));
        send(8'($urandom()));
        repeat (3) @(posedge clk);
        rd(A_RXF, 32'h0, 32'h1);
        send(8'($urandom()));
        repeat (3) @(posedge clk);
        rd(A_RXF, 32'h1, 32'h1);
        // codes above seven fall back to one second; flipping bits 5-7 must not change the period
        cfg = {3'($urandom()), 1'b0, 4'h9};
        for (int j = 0; j < 2; j++)
        begin
            if (j == 1)
                cfg[7:5] = ~cfg[7:5];
            wr(A_CFG, {24'h0, cfg}, 4'h1);
            tick_wait(n);
            tick_wait(n);
            chk(33'(n), 33'(SEC));
        end
        apb(1'b0, 14'hcb8, 32'h0, 4'h0, 32'hffffffff, 1'b1);
        apb(1'b1, 14'hc91, 32'h0, 4'hf, 32'h0, 1'b1);
        rd(A_CFG, {24'h0, cfg}, 32'h1f);
        report_and_stop();
    end
endmodule : tb
